// file: hw/lbsr_buf2.sv
// Two-entry valid/ready buffer for outgoing words
`timescale 1ns/100ps
module lbsr_buf2 #(
	parameter int W = 32 // Word width
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Sync reset, low active
	input wire logic ce, // Clock enable
	input wire logic in_valid, // Word offered
	output logic in_ready, // Room for a word
	input wire logic [W-1:0] in_data, // Word in
	output logic out_valid, // Word held
	input wire logic out_ready, // Word taken
	output logic [W-1:0] out_data // Oldest word
);
	// Whole buffer state in one struct
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic [1:0] cnt;
	} lbsr_buf_t;
	lbsr_buf_t st_ff, nxt_st;
	logic push, pop;
	// Handshakes on both sides
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		nxt_st = st_ff;
		if (pop) begin
			nxt_st.mem[0] = st_ff.mem[1];
		end
		if (push) begin
			// New word lands behind whatever stays
			nxt_st.mem[st_ff.cnt - {1'b0, pop}] = in_data;
		end
		nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
	end
	// Register the state
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end
	assign in_ready = (st_ff.cnt != 2'h2);
	assign out_valid = (st_ff.cnt != 2'h0);
	assign out_data = st_ff.mem[0];
endmodule

// file: hw/lbsr_defines.svh
// Constants for the logger bus sample responder
`ifndef LBSR_DEFINES_SVH
`define LBSR_DEFINES_SVH
`define LBSR_ADDR_MAX 4'he
`define LBSR_MODE_TRIG 3'h7
`define LBSR_WORD_W 32
`define LBSR_ITEMS 16
`define LBSR_IDX_W 4
`define LBSR_DIAG_CHOP 7
`define LBSR_DIAG_DET 6
`define LBSR_DIAG_PLL 5
`define LBSR_DIAG_SYNC 4
`define LBSR_SIG_WORD 32'h0000a5c3
`endif

// file: hw/lbsr_pkg.sv
// Types for the logger bus sample responder
package lbsr_pkg;
	typedef enum logic [3:0] {
		LBSR_CO2_DENS, LBSR_H2O_DENS, LBSR_CO2_ABS, LBSR_H2O_ABS,
		LBSR_PRES, LBSR_TEMP, LBSR_AUX1, LBSR_COOLER, LBSR_DIAG,
		LBSR_BW, LBSR_DELAY, LBSR_GAIN_PCT, LBSR_NONE
	} lbsr_item_t;
	typedef enum {LBSR_IDLE, LBSR_RX, LBSR_LOAD, LBSR_TX} lbsr_state_t;
endpackage

// file: hw/lbsr_responder.sv
// Addressed responder serving sample sets to a datalogger bus
// Summary of operation
// - Bus address settable from zero to fourteen
// - Mode codes zero to seven; seven triggers
// - Mode one: CO2 then H2O absorptance
// - Mode two: pressure, temperature, aux one, cooler
// - Mode three: diagnostic, bandwidth, delay interval
// - Mode four: first eleven items in order, no gain percentage
// - Mode zero densities; mode five adds pressure
// - Mode six: densities, pressure, diagnostic
// - Mode seven: latched densities, gain, pressure
// - Latched set holds until next trigger
// - Every word shifted least-significant bit first
// - Diagnostic bits 7..4 are health flags
// - Diagnostic bits 3..0 hold gain code
`timescale 1ns/100ps
`include "lbsr_defines.svh"
module lbsr_responder #(
	parameter int W = `LBSR_WORD_W // Data word width
) (
	input wire logic clk_sys, // System clock, 100 MHz
	input wire logic rst_n, // Sync reset, low active
	input wire logic ce, // Clock enable
	input wire logic [3:0] responder_bus_address, // Own address
	input wire logic bus_clk_pin, // Bus shift clock pin
	input wire logic bus_data_in, // Bus data pin, input side
	input wire logic bus_trig_pin, // Group trigger broadcast pin
	input wire logic bus_sel_pin, // Frame select pin, high in frame
	output logic bus_data_out, // Bus data pin, output side
	output logic bus_data_oe, // High while driving data
	input wire logic [W-1:0] co2_dens, // CO2 molar density
	input wire logic [W-1:0] h2o_dens, // H2O molar density
	input wire logic [W-1:0] co2_abs, // CO2 absorptance
	input wire logic [W-1:0] h2o_abs, // H2O absorptance
	input wire logic [W-1:0] pres_kpa, // Pressure
	input wire logic [W-1:0] temp_c, // Temperature
	input wire logic [W-1:0] aux1, // Auxiliary channel one
	input wire logic [W-1:0] cooler_v, // Cooler signal
	input wire logic [W-1:0] bandwidth, // Bandwidth
	input wire logic [W-1:0] delay_ivl, // Delay interval
	input wire logic [W-1:0] gain_pct, // Gain control percentage
	input wire logic [3:0] health, // Chopper, detector, PLL, sync
	input wire logic [3:0] gain_code, // Gain code n
	output logic addr_err, // Configured address out of range
	output logic [7:0] diag_byte // Packed diagnostic byte
);
	// Block state in one struct; the word buffer keeps its own in u_buf
	typedef struct packed {
		lbsr_pkg::lbsr_state_t state;
		logic [2:0] clk_s, dat_s, trg_s, sel_s; // Pin synchronisers
		logic [7:0] rx_sh; // Request: mode then address
		logic [2:0] rx_cnt;
		logic [2:0] mode;
		logic [`LBSR_IDX_W-1:0] idx; // Item within mode list
		logic sig_done; // Signature word pushed
		logic [W-1:0] tx_sh;
		logic [5:0] tx_cnt;
		logic tx_busy;
		logic [3:0][W-1:0] snap; // Trigger-latched set
		logic dout, oe, aerr;
		logic [7:0] diag;
	} lbsr_st_t;
	lbsr_st_t st_ff, nxt_st;
	logic bf_in_valid, bf_in_ready, bf_out_valid, bf_out_ready;
	logic [W-1:0] bf_in_data, bf_out_data;
	lbsr_pkg::lbsr_item_t item;
	logic clk_rise, clk_fall, trg_rise, sel;

	// Item list per mode, terminated by LBSR_NONE
	function automatic lbsr_pkg::lbsr_item_t item_of(
		input logic [2:0] m, input logic [3:0] i);
		lbsr_pkg::lbsr_item_t it;
		it = lbsr_pkg::LBSR_NONE;
		case (m)
			3'h0: if (i < 4'h2) it = lbsr_pkg::lbsr_item_t'(i);
			3'h1: if (i < 4'h2) it = lbsr_pkg::lbsr_item_t'(i + 4'h2);
			3'h2: if (i < 4'h4) it = lbsr_pkg::lbsr_item_t'(i + 4'h4);
			3'h3: if (i < 4'h3) it = lbsr_pkg::lbsr_item_t'(i + 4'h8);
			3'h4: if (i < 4'hb) it = lbsr_pkg::lbsr_item_t'(i);
			3'h5: begin
				if (i < 4'h2) it = lbsr_pkg::lbsr_item_t'(i);
				else if (i == 4'h2) it = lbsr_pkg::LBSR_PRES;
			end
			3'h6: begin
				if (i < 4'h2) it = lbsr_pkg::lbsr_item_t'(i);
				else if (i == 4'h2) it = lbsr_pkg::LBSR_PRES;
				else if (i == 4'h3) it = lbsr_pkg::LBSR_DIAG;
			end
			default: if (i < 4'h4) it = lbsr_pkg::lbsr_item_t'(i + 4'h0);
		endcase
		return it;
	endfunction

	// Word value of one item
	function automatic logic [W-1:0] value_of(
		input lbsr_pkg::lbsr_item_t it, input logic [7:0] dg);
		case (it)
			lbsr_pkg::LBSR_CO2_DENS: value_of = co2_dens;
			lbsr_pkg::LBSR_H2O_DENS: value_of = h2o_dens;
			lbsr_pkg::LBSR_CO2_ABS: value_of = co2_abs;
			lbsr_pkg::LBSR_H2O_ABS: value_of = h2o_abs;
			lbsr_pkg::LBSR_PRES: value_of = pres_kpa;
			lbsr_pkg::LBSR_TEMP: value_of = temp_c;
			lbsr_pkg::LBSR_AUX1: value_of = aux1;
			lbsr_pkg::LBSR_COOLER: value_of = cooler_v;
			lbsr_pkg::LBSR_DIAG: value_of = {{(W-8){1'b0}}, dg};
			lbsr_pkg::LBSR_BW: value_of = bandwidth;
			lbsr_pkg::LBSR_DELAY: value_of = delay_ivl;
			lbsr_pkg::LBSR_GAIN_PCT: value_of = gain_pct;
			default: value_of = '0;
		endcase
	endfunction

	// Outgoing words wait here so a slow shifter drops nothing
	lbsr_buf2 #(.W(W)) u_buf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.in_valid(bf_in_valid),
		.in_ready(bf_in_ready),
		.in_data(bf_in_data),
		.out_valid(bf_out_valid),
		.out_ready(bf_out_ready),
		.out_data(bf_out_data)
	);

	// Edges read only the second synchroniser stage onward
	assign clk_rise = st_ff.clk_s[1] && !st_ff.clk_s[2];
	assign clk_fall = !st_ff.clk_s[1] && st_ff.clk_s[2];
	assign trg_rise = st_ff.trg_s[1] && !st_ff.trg_s[2];
	assign sel = st_ff.sel_s[1];
	assign item = item_of(st_ff.mode, st_ff.idx);
	// Shifter takes a word whenever it is free; idle and receive drain
	// leftovers of a cut frame so they never leak into the next answer
	assign bf_out_ready = !st_ff.tx_busy;

	// Next-state logic
	always_comb begin
		nxt_st = st_ff;
		bf_in_valid = 1'b0;
		bf_in_data = '0;
		nxt_st.clk_s = {st_ff.clk_s[1:0], bus_clk_pin};
		nxt_st.dat_s = {st_ff.dat_s[1:0], bus_data_in};
		nxt_st.trg_s = {st_ff.trg_s[1:0], bus_trig_pin};
		nxt_st.sel_s = {st_ff.sel_s[1:0], bus_sel_pin};
		nxt_st.aerr = (responder_bus_address > `LBSR_ADDR_MAX);
		// Diagnostic byte: flags high, gain code low
		nxt_st.diag = {health, gain_code};
		// Capture on broadcast; reads leave the snapshot alone
		if (trg_rise) begin
			nxt_st.snap[0] = co2_dens;
			nxt_st.snap[1] = h2o_dens;
			nxt_st.snap[2] = gain_pct;
			nxt_st.snap[3] = pres_kpa;
		end
		case (st_ff.state)
			lbsr_pkg::LBSR_IDLE: begin
				nxt_st.oe = 1'b0;
				nxt_st.rx_cnt = 3'h0;
				// Only a fresh frame start opens a request, one per frame
				if (sel && !st_ff.sel_s[2]) begin
					nxt_st.state = lbsr_pkg::LBSR_RX;
				end
			end
			lbsr_pkg::LBSR_RX: begin
				// Request byte arrives LSB first on rising edges
				if (clk_rise) begin
					nxt_st.rx_sh = {st_ff.dat_s[1], st_ff.rx_sh[7:1]};
					nxt_st.rx_cnt = st_ff.rx_cnt + 3'h1;
					if (st_ff.rx_cnt == 3'h7) begin
						nxt_st.mode = nxt_st.rx_sh[2:0];
						nxt_st.idx = '0;
						nxt_st.sig_done = 1'b0;
						// Foreign or invalid address: stay silent
						if (nxt_st.rx_sh[7:4] == responder_bus_address &&
							!st_ff.aerr) begin
							nxt_st.state = lbsr_pkg::LBSR_LOAD;
						end else begin
							nxt_st.state = lbsr_pkg::LBSR_IDLE;
						end
					end
				end
			end
			lbsr_pkg::LBSR_LOAD: begin
				// Signature first, then the mode's items
				if (bf_in_ready) begin
					bf_in_valid = 1'b1;
					if (!st_ff.sig_done) begin
						bf_in_data = W'(`LBSR_SIG_WORD);
						nxt_st.sig_done = 1'b1;
					end else if (st_ff.mode == `LBSR_MODE_TRIG) begin
						bf_in_data = st_ff.snap[st_ff.idx[1:0]];
						nxt_st.idx = st_ff.idx + 4'h1;
					end else begin
						bf_in_data = value_of(item, st_ff.diag);
						nxt_st.idx = st_ff.idx + 4'h1;
					end
					if (st_ff.sig_done && item_of(st_ff.mode,
						st_ff.idx + 4'h1) == lbsr_pkg::LBSR_NONE) begin
						nxt_st.state = lbsr_pkg::LBSR_TX;
					end
				end
			end
			default: begin
				// Last bit stays on the line until the frame ends
				nxt_st.state = lbsr_pkg::LBSR_TX;
			end
		endcase
		// Shifter drains while words are still loaded, so two slots do
		if (st_ff.state == lbsr_pkg::LBSR_LOAD ||
			st_ff.state == lbsr_pkg::LBSR_TX) begin
			// Shift words out LSB first, change on falling edge
			if (!st_ff.tx_busy && bf_out_valid) begin
				nxt_st.tx_sh = bf_out_data;
				nxt_st.tx_cnt = '0;
				nxt_st.tx_busy = 1'b1;
			end else if (st_ff.tx_busy && clk_fall) begin
				nxt_st.oe = 1'b1;
				nxt_st.dout = st_ff.tx_sh[0];
				nxt_st.tx_sh = st_ff.tx_sh >> 1;
				nxt_st.tx_cnt = st_ff.tx_cnt + 6'h1;
				if (st_ff.tx_cnt == 6'(W - 1)) begin
					nxt_st.tx_busy = 1'b0;
				end
			end
		end
		// Frame end releases the line at once
		if (!sel && st_ff.state != lbsr_pkg::LBSR_IDLE) begin
			nxt_st.state = lbsr_pkg::LBSR_IDLE;
			nxt_st.oe = 1'b0;
			nxt_st.tx_busy = 1'b0;
		end
	end

	// Register the state
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign bus_data_out = st_ff.dout;
	assign bus_data_oe = st_ff.oe;
	assign addr_err = st_ff.aerr;
	assign diag_byte = st_ff.diag;
endmodule

// file: sim/lbsr_checker.sv
// Port checker for the logger bus sample responder
`timescale 1ns/100ps
`include "lbsr_defines.svh"
module lbsr_checker (
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Sync reset, low active
	input wire logic ce, // Clock enable
	input wire logic [3:0] responder_bus_address, // Own address
	input wire logic bus_clk_pin, // Bus shift clock
	input wire logic bus_sel_pin, // Frame select
	input wire logic bus_data_out, // Data pin value
	input wire logic bus_data_oe, // Data pin enable
	input wire logic [3:0] health, // Health flags
	input wire logic [3:0] gain_code, // Gain code
	input wire logic addr_err, // Address error
	input wire logic [7:0] diag_byte // Diagnostic byte
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Select drop as the synchroniser sees it
	sequence s_sel_drop;
		bus_sel_pin ##1 !bus_sel_pin;
	endsequence
	// Start of a driven answer
	sequence s_oe_rise;
		!bus_data_oe ##1 bus_data_oe;
	endsequence
	chk_diag_flags: assert property ($past(rst_n) && ce |=>
		diag_byte[7:4] == $past(health)) else $error("diag flags wrong");
	chk_gain_code: assert property ($past(rst_n) && ce |=>
		diag_byte[3:0] == $past(gain_code)) else $error("gain code wrong");
	chk_addr_range: assert property ($past(rst_n) && ce |=>
		addr_err == ($past(responder_bus_address) > `LBSR_ADDR_MAX))
		else $error("address range flag wrong");
	chk_bad_addr: assert property (addr_err |-> !bus_data_oe)
		else $error("drove with bad address");
	chk_oe_framed: assert property (s_oe_rise |-> $past(bus_sel_pin, 8))
		else $error("drive started outside a frame");
	chk_sel_release: assert property (s_sel_drop |-> ##[1:8] !bus_data_oe)
		else $error("drive held after frame end");
	// Bits move only after a shift clock fall; a limit of 3 cycles of lag
	chk_bit_moment: assert property (bus_data_oe && $past(bus_data_oe) &&
		$changed(bus_data_out) |-> !$past(bus_clk_pin, 3))
		else $error("data bit moved off the falling edge");
	chk_bit_hold: assert property (bus_clk_pin [*4] |-> $stable(bus_data_out))
		else $error("data bit moved while clock high");
endmodule
bind lbsr_responder lbsr_checker lbsr_checker_i (.clk_sys, .rst_n, .ce,
	.responder_bus_address, .bus_clk_pin, .bus_sel_pin, .bus_data_out,
	.bus_data_oe, .health, .gain_code, .addr_err, .diag_byte);

// file: sim/lbsr_logger_model.sv
// Datalogger bus master model issuing request frames
`timescale 1ns/100ps
module lbsr_logger_model (
	input wire logic clk_sys, // System clock
	input wire logic bus_data_out, // Responder data
	input wire logic bus_data_oe, // Responder enable
	output logic bus_clk_pin, // Shift clock, still outside frames
	output logic bus_sel_pin, // Frame select
	output logic bus_trig_pin, // Group trigger
	output logic bus_data_in // Resolved data wire
);
	int half = 8; // Clock phase in system cycles
	logic m_oe = 1'b0; // Master drives the wire
	logic m_bit = 1'b0; // Master bit
	logic seen_oe = 1'b0; // Responder drove in this frame
	logic sel_q = 1'b0; // Select one clock ago
	logic [31:0] words [12]; // Words read back
	// Pull-up wins when nobody drives, so a stale bit never lingers
	assign bus_data_in = bus_data_oe ? bus_data_out : (m_oe ? m_bit : 1'b1);
	initial begin
		bus_clk_pin = 1'b0;
		bus_sel_pin = 1'b0;
		bus_trig_pin = 1'b0;
	end
	// Drive flag cleared at each frame start, set by any drive
	always @(posedge clk_sys) begin
		sel_q <= bus_sel_pin;
		if (bus_data_oe === 1'b1) seen_oe <= 1'b1;
		else if (bus_sel_pin && !sel_q) seen_oe <= 1'b0;
	end
	// One request then n words, all least significant bit first
	task automatic read_frame(input logic [3:0] a, input logic [2:0] m,
		input int n);
		logic [7:0] req;
		req = {a, 1'b0, m};
		bus_sel_pin = 1'b1;
		m_oe = 1'b1;
		for (int i = 0; i < 8; i++) begin
			m_bit = req[i];
			repeat (half) @(negedge clk_sys);
			bus_clk_pin = 1'b1;
			repeat (half) @(negedge clk_sys);
			bus_clk_pin = 1'b0;
		end
		m_oe = 1'b0;
		for (int j = 0; j < 32 * n; j++) begin
			repeat (half) @(negedge clk_sys);
			bus_clk_pin = 1'b1;
			words[j / 32][j % 32] = bus_data_in;
			repeat (half) @(negedge clk_sys);
			bus_clk_pin = 1'b0;
		end
		repeat (half) @(negedge clk_sys);
		bus_sel_pin = 1'b0;
		repeat (12) @(negedge clk_sys);
	endtask
	// Broadcast capture pulse to every responder
	task automatic group_trigger();
		bus_trig_pin = 1'b1;
		repeat (8) @(negedge clk_sys);
		bus_trig_pin = 1'b0;
		repeat (8) @(negedge clk_sys);
	endtask
endmodule

// file: sim/logger_bus_sample_responder_bench.sv
// Self-checking bench for the logger bus sample responder
`timescale 1ns/100ps
`include "lbsr_defines.svh"
module logger_bus_sample_responder_bench;
	logic clk_sys = 1'b0; // 100 MHz clock
	logic rst_n = 1'b0; // Reset, low active
	logic [3:0] own_addr = 4'h3; // Configured address
	logic [3:0] health = 4'ha; // Health flags
	logic [3:0] gain_code = 4'hd; // Gain code
	logic [31:0] v [12]; // Item values, slot 8 is expected diag
	logic bus_clk_pin, bus_sel_pin, bus_trig_pin, bus_data_in;
	logic bus_data_out, bus_data_oe, addr_err;
	logic [7:0] diag_byte;
	int fails = 0;
	int check_count = 0;
	// Item order per mode, one nibble per item, lowest first
	localparam logic [43:0] LST [8] = '{44'h10, 44'h32, 44'h7654, 44'ha98,
		44'ha9876543210, 44'h410, 44'h8410, 44'h4b10};
	localparam int CNT [8] = '{2, 2, 4, 3, 11, 3, 4, 4};
	always #5 clk_sys = ~clk_sys;
	lbsr_responder lbsr_responder_i (.clk_sys, .rst_n, .ce(1'b1),
		.responder_bus_address(own_addr), .bus_clk_pin, .bus_data_in,
		.bus_trig_pin, .bus_sel_pin, .bus_data_out, .bus_data_oe,
		.co2_dens(v[0]), .h2o_dens(v[1]), .co2_abs(v[2]), .h2o_abs(v[3]),
		.pres_kpa(v[4]), .temp_c(v[5]), .aux1(v[6]), .cooler_v(v[7]),
		.bandwidth(v[9]), .delay_ivl(v[10]), .gain_pct(v[11]), .health,
		.gain_code, .addr_err, .diag_byte);
	lbsr_logger_model lbsr_logger_model_i (.clk_sys, .bus_data_out,
		.bus_data_oe, .bus_clk_pin, .bus_sel_pin, .bus_trig_pin, .bus_data_in);
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp, input string what);
		cmp_word({31'h0, got}, {31'h0, exp}, what);
	endtask
	// Full frame at own address, signature then listed items
	task automatic read_check(input logic [2:0] m, input logic [31:0] e [12]);
		lbsr_logger_model_i.read_frame(own_addr, m, CNT[m] + 1);
		cmp_word(lbsr_logger_model_i.words[0], `LBSR_SIG_WORD, "sig");
		for (int k = 0; k < CNT[m]; k++) begin
			cmp_word(lbsr_logger_model_i.words[k + 1], e[LST[m][4 * k +: 4]],
				"item");
		end
	endtask
	task automatic test_modes;
		for (int m = 0; m < 7; m++) read_check(3'(m), v);
		cmp_word({24'h0, diag_byte}, v[8], "diag byte");
		health = 4'h5;
		gain_code = 4'h2;
		v[8] = 32'h52;
		read_check(3'h3, v);
		$display("test_modes done");
	endtask
	task automatic test_addr;
		lbsr_logger_model_i.read_frame(4'h4, 3'h0, 3);
		cmp_bit(lbsr_logger_model_i.seen_oe, 1'b0, "foreign drive");
		own_addr = 4'he;
		lbsr_logger_model_i.half = 20;
		read_check(3'h6, v);
		lbsr_logger_model_i.half = 8;
		own_addr = 4'hf;
		repeat (4) @(negedge clk_sys);
		cmp_bit(addr_err, 1'b1, "address 15 flag");
		lbsr_logger_model_i.read_frame(4'hf, 3'h0, 3);
		cmp_bit(lbsr_logger_model_i.seen_oe, 1'b0, "drive at 15");
		own_addr = 4'h3;
		repeat (4) @(negedge clk_sys);
		cmp_bit(addr_err, 1'b0, "address flag stuck");
		$display("test_addr done");
	endtask
	// Snapshot must survive changed inputs and repeated reads
	task automatic test_trigger;
		logic [31:0] snap [12];
		lbsr_logger_model_i.group_trigger();
		snap = v;
		for (int i = 0; i < 12; i++) v[i] = ~v[i];
		repeat (2) read_check(3'h7, snap);
		lbsr_logger_model_i.group_trigger();
		read_check(3'h7, v);
		$display("test_trigger done");
	endtask
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 12; i++) v[i] = 32'(i + 1) * 32'h9e3779b9;
		v[8] = 32'had;
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		test_modes();
		test_addr();
		test_trigger();
		finish_test();
	end
	// Watchdog well beyond the expected run
	initial begin
		#800000;
		fails++;
		$display("Error at %0t: watchdog expired", $time);
		finish_test();
	end
endmodule
